// >>> logic/exec_core.sv
// Execution core for add, AND, bit and clear instructions with Wishbone access
`timescale 1ns/1ps
`include "exec_cfg.svh"
module exec_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Execution state
	output logic busy_o,
	output logic done_o
);
	import exec_pkg::*;

	alu_if alu ();
	seq_if seq ();

	logic [13:0] ir;
	logic [7:0] wreg;
	logic carry;
	logic digit_carry;
	logic zero;
	logic presc_on;
	logic [12:0] pc;
	logic [7:0] presc;
	logic [7:0] file_mem [0:127];
	logic skip_taken;
	logic bad_op;
	logic wb_req;
	logic bus_wr;
	logic sw_ok;
	logic [6:0] fa;
	logic dest_f;
	op_kind_t kind;
	logic wr_w;
	logic wr_f;
	logic upd_cz;
	logic upd_z;
	logic timer_hit;
	logic presc_tick;
	logic [31:0] next_dat;
	logic [3:0] exec_len;
	logic [8:0] chk_sum;
	logic [4:0] chk_low;

	exec_alu u_alu (
		.a(alu)
	);

	exec_seq u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.s(seq)
	);

	// Bus request decode
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = wb_req && wb_we_i;
	assign sw_ok = bus_wr && wb_sel_i[0] && !seq.busy;

	// Instruction fields
	assign fa = ir[6:0];
	assign dest_f = ir[`F_DEST];

	always_comb begin
		kind = op_bad;
		if (ir[13:8] == `OPC_ADD_FILE) begin
			kind = op_add_file;
		end else if (ir[13:8] == `OPC_AND_FILE) begin
			kind = op_and_file;
		end else if (ir[13:7] == `OPC_CLR_FILE) begin
			kind = op_clr_file;
		end else if (ir[13:10] == `OPC_BIT_CLR) begin
			kind = op_bit_clr;
		end else if (ir[13:10] == `OPC_BIT_SET) begin
			kind = op_bit_set;
		end else if (ir[13:10] == `OPC_BIT_SKIP) begin
			kind = op_bit_skip;
		end else if (ir[13:9] == `OPC_ADD_LIT) begin
			kind = op_add_lit;
		end else if (ir[13:8] == `OPC_AND_LIT) begin
			kind = op_and_lit;
		end
	end

	// Destination and flag selection
	always_comb begin
		wr_w = 1'b0;
		wr_f = 1'b0;
		upd_cz = 1'b0;
		upd_z = 1'b0;
		case (kind)
			op_add_lit: begin
				wr_w = 1'b1;
				upd_cz = 1'b1;
				upd_z = 1'b1;
			end
			op_and_lit: begin
				wr_w = 1'b1;
				upd_z = 1'b1;
			end
			op_add_file: begin
				wr_w = !dest_f;
				wr_f = dest_f;
				upd_cz = 1'b1;
				upd_z = 1'b1;
			end
			op_and_file: begin
				wr_w = !dest_f;
				wr_f = dest_f;
				upd_z = 1'b1;
			end
			op_bit_clr, op_bit_set: wr_f = 1'b1;
			op_clr_file: begin
				wr_f = 1'b1;
				upd_z = 1'b1;
			end
			default: wr_w = 1'b0;
		endcase
	end

	// ALU and sequencer hookup
	assign alu.kind = kind;
	assign alu.w = wreg;
	assign alu.f = file_mem[fa];
	assign alu.lit = ir[7:0];
	assign alu.bidx = ir[`F_BIT_HI:`F_BIT_LO];
	assign seq.start = bus_wr && wb_adr_i == `OFF_INSTR && wb_sel_i[1:0] == 2'h3 && !seq.busy;
	assign seq.two_cycle = (kind == op_bit_skip) && alu.skip;
	assign timer_hit = seq.commit && wr_f && fa == `TIMER_ADDR;
	assign presc_tick = seq.commit || (seq.done && seq.second);

	// Instruction register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir <= `RST_IR;
		end else if (seq.start) begin
			ir <= wb_dat_i[13:0];
		end
	end

	// Working register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wreg <= `RST_WREG;
		end else if (seq.commit && wr_w) begin
			wreg <= alu.res;
		end else if (sw_ok && wb_adr_i == `OFF_WREG) begin
			wreg <= wb_dat_i[7:0];
		end
	end

	// File registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 128; i++) begin
				file_mem[i] <= 8'h00;
			end
		end else if (seq.commit && wr_f) begin
			file_mem[fa] <= alu.res;
		end else if (sw_ok && wb_adr_i[11:9] == `FILE_WIN_HI) begin
			file_mem[wb_adr_i[8:2]] <= wb_dat_i[7:0];
		end
	end

	// Status flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carry <= `RST_FLAG;
			digit_carry <= `RST_FLAG;
			zero <= `RST_FLAG;
		end else if (seq.commit) begin
			if (upd_cz) begin
				carry <= alu.carry;
				digit_carry <= alu.digit_carry;
			end
			if (upd_z) begin
				zero <= alu.zero;
			end
		end else if (sw_ok && wb_adr_i == `OFF_STATUS) begin
			carry <= wb_dat_i[`ST_C];
			digit_carry <= wb_dat_i[`ST_DIGIT];
			zero <= wb_dat_i[`ST_Z];
		end
	end

	// Prescaler assignment control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc_on <= `RST_CTRL;
		end else if (bus_wr && wb_sel_i[0] && wb_adr_i == `OFF_CTRL) begin
			presc_on <= wb_dat_i[`CTL_PRESC_ON];
		end
	end

	// Timer prescaler
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc <= `RST_PRESC;
		end else if (timer_hit && presc_on) begin
			presc <= `RST_PRESC;
		end else if (presc_tick && presc_on) begin
			presc <= presc + 8'h01;
		end
	end

	// Program counter, skip and bad opcode status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc <= `RST_PC;
		end else if (seq.done) begin
			pc <= skip_taken || seq.two_cycle ? pc + 13'h0002 : pc + 13'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			skip_taken <= 1'b0;
			bad_op <= 1'b0;
		end else if (seq.start) begin
			skip_taken <= 1'b0;
			bad_op <= 1'b0;
		end else if (seq.commit) begin
			skip_taken <= seq.two_cycle;
			bad_op <= (kind == op_bad);
		end
	end

	// Bus read mux
	always_comb begin
		next_dat = 32'h0000_0000;
		if (wb_adr_i[11:9] == `FILE_WIN_HI) begin
			next_dat[7:0] = file_mem[wb_adr_i[8:2]];
		end else begin
			case (wb_adr_i)
				`OFF_INSTR: next_dat[13:0] = ir;
				`OFF_WREG: next_dat[7:0] = wreg;
				`OFF_STATUS: begin
					next_dat[`ST_C] = carry;
					next_dat[`ST_DIGIT] = digit_carry;
					next_dat[`ST_Z] = zero;
				end
				`OFF_CTRL: begin
					next_dat[`CTL_PRESC_ON] = presc_on;
					next_dat[`CTL_BUSY] = seq.busy;
					next_dat[`CTL_SKIP] = skip_taken;
					next_dat[`CTL_BAD] = bad_op;
				end
				`OFF_PC: next_dat[12:0] = pc;
				`OFF_PRESC: next_dat[7:0] = presc;
				default: next_dat = 32'h0000_0000;
			endcase
		end
	end

	// Bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			wb_dat_o <= next_dat;
		end
	end

	// Execution state outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			busy_o <= seq.start || (seq.busy && !seq.done);
			done_o <= seq.done;
		end
	end

	// Checking helpers
	assign chk_sum = {1'b0, wreg} + {1'b0, (kind == op_add_lit) ? ir[7:0] : alu.f};
	assign chk_low = {1'b0, wreg[3:0]} + {1'b0, (kind == op_add_lit) ? ir[3:0] : alu.f[3:0]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exec_len <= 4'h0;
		end else if (seq.start) begin
			exec_len <= 4'h1;
		end else if (seq.busy) begin
			exec_len <= exec_len + 4'h1;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_single_len: assert property (seq.done && !seq.second |-> exec_len == 4'h4)
		else $error("single cycle instruction not four clocks");
	a_double_len: assert property (seq.done && seq.second |-> exec_len == 4'h8)
		else $error("two cycle instruction not eight clocks");
	a_skip_taken: assert property (seq.commit && kind == op_bit_skip && alu.skip
		|=> seq.second [*4] ##1 !seq.busy)
		else $error("skip did not run a four clock no-operation cycle");
	a_skip_flags: assert property (seq.commit && kind == op_bit_skip
		|=> $stable(wreg) && $stable(carry) && $stable(zero) && $stable(digit_carry))
		else $error("bit test changed state");
	a_add_lit: assert property (seq.commit && kind == op_add_lit
		|=> wreg == $past(chk_sum[7:0]))
		else $error("literal add result wrong");
	a_add_flags: assert property (seq.commit && (kind == op_add_lit || kind == op_add_file)
		|=> carry == $past(chk_sum[8]) && digit_carry == $past(chk_low[4])
		&& zero == ($past(chk_sum[7:0]) == 8'h00))
		else $error("add flags wrong");
	a_and_file: assert property (seq.commit && kind == op_and_file && !dest_f
		|=> wreg == ($past(wreg) & $past(alu.f)) && $stable(carry))
		else $error("file AND result wrong");
	a_add_dest: assert property (seq.commit && kind == op_add_file && dest_f
		|=> file_mem[fa] == $past(chk_sum[7:0]) && $stable(wreg))
		else $error("file add destination wrong");
	a_and_lit: assert property (seq.commit && kind == op_and_lit
		|=> wreg == ($past(wreg) & $past(alu.lit)) && $stable(carry)
		&& zero == (wreg == 8'h00))
		else $error("literal AND wrong");
	a_bit_clear: assert property (seq.commit && kind == op_bit_clr
		|=> file_mem[fa][alu.bidx] == 1'b0 && $stable(zero) && $stable(carry))
		else $error("bit clear wrong");
	a_bit_set: assert property (seq.commit && kind == op_bit_set
		|=> file_mem[fa][alu.bidx] == 1'b1 && $stable(zero) && $stable(carry))
		else $error("bit set wrong");
	a_clear_file: assert property (seq.commit && kind == op_clr_file
		|=> file_mem[fa] == 8'h00 && zero)
		else $error("clear file wrong");
	a_presc_clear: assert property (timer_hit && presc_on |=> presc == 8'h00)
		else $error("prescaler not cleared on timer write");

	c_add_lit: cover property (seq.commit && kind == op_add_lit);
	c_skip: cover property (seq.done && seq.second);
	c_presc_clear: cover property (timer_hit && presc_on && presc != 8'h00);
	c_file_dest: cover property (seq.commit && kind == op_and_file && dest_f);
endmodule : exec_core

// >>> logic/exec_cfg.svh
// Register map, instruction fields and timing of the execution unit
// Operation
// - Timer write to file clears assigned prescaler
// - Taken skip takes two cycles
// - Literal add into working register, three flags
// - AND working with file, zero flag only
// - Destination bit picks working or file
// - Add working and file, three flags
// - Bit clear touches one bit, no flags
// - Bit set touches one bit, no flags
// - AND literal into working, zero flag only
// - Bit test skips next if bit set, two cycles
// - Clear file writes zero, sets zero
// - Instruction cycle is four clock periods
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
// Byte offsets on the register bus
`define OFF_INSTR 12'h000
`define OFF_WREG 12'h004
`define OFF_STATUS 12'h008
`define OFF_CTRL 12'h00C
`define OFF_PC 12'h010
`define OFF_PRESC 12'h014
`define FILE_WIN_HI 3'h1
// Status and control fields
`define ST_C 0
`define ST_DIGIT 1
`define ST_Z 2
`define CTL_PRESC_ON 0
`define CTL_BUSY 8
`define CTL_SKIP 9
`define CTL_BAD 10
// Reset values
`define RST_WREG 8'h00
`define RST_FLAG 1'b0
`define RST_CTRL 1'b0
`define RST_PC 13'h0000
`define RST_PRESC 8'h00
`define RST_IR 14'h0000
// Instruction fields and opcodes
`define F_DEST 7
`define F_BIT_HI 9
`define F_BIT_LO 7
`define OPC_ADD_FILE 6'h07
`define OPC_AND_FILE 6'h05
`define OPC_CLR_FILE 7'h03
`define OPC_BIT_CLR 4'h4
`define OPC_BIT_SET 4'h5
`define OPC_BIT_SKIP 4'h7
`define OPC_ADD_LIT 5'h1F
`define OPC_AND_LIT 6'h39
// Timer location in the file space
`define TIMER_ADDR 7'h01
// Timing: clock periods per instruction cycle
`define OSC_PER_CYCLE 4
`define QTR_LAST 2'h3
`endif

// >>> logic/exec_pkg.sv
// Types shared by the execution unit modules
package exec_pkg;
	typedef enum logic [3:0] {
		op_bad, op_add_lit, op_and_lit, op_add_file, op_and_file,
		op_bit_clr, op_bit_set, op_bit_skip, op_clr_file
	} op_kind_t;
	typedef enum logic [2:0] {
		s_idle = 3'h1,
		s_first = 3'h2,
		s_second = 3'h4
	} seq_state_t;
endpackage : exec_pkg

// >>> logic/exec_ifs.sv
// Interfaces between the core, its ALU and its cycle sequencer
`timescale 1ns/1ps
interface alu_if;
	exec_pkg::op_kind_t kind;
	logic [7:0] w;
	logic [7:0] f;
	logic [7:0] lit;
	logic [2:0] bidx;
	logic [7:0] res;
	logic carry;
	logic digit_carry;
	logic zero;
	logic skip;
	modport core(output kind, w, f, lit, bidx, input res, carry, digit_carry, zero, skip);
	modport unit(input kind, w, f, lit, bidx, output res, carry, digit_carry, zero, skip);
endinterface : alu_if

interface seq_if;
	logic start;
	logic two_cycle;
	logic busy;
	logic commit;
	logic done;
	logic second;
	modport core(output start, two_cycle, input busy, commit, done, second);
	modport seq(input start, two_cycle, output busy, commit, done, second);
endinterface : seq_if

// >>> logic/exec_alu.sv
// Combinational ALU for add, AND, bit and clear operations
`timescale 1ns/1ps
module exec_alu (
	// Operands and results
	alu_if.unit a
);
	import exec_pkg::*;
	logic [7:0] opnd;
	logic [8:0] sum;
	logic [4:0] low;
	logic [7:0] mask;

	always_comb begin
		opnd = (a.kind == op_add_lit || a.kind == op_and_lit) ? a.lit : a.f;
		sum = {1'b0, a.w} + {1'b0, opnd};
		low = {1'b0, a.w[3:0]} + {1'b0, opnd[3:0]};
		mask = 8'h01 << a.bidx;
		a.carry = sum[8];
		a.digit_carry = low[4];
		a.skip = 1'b0;
		case (a.kind)
			op_add_lit, op_add_file: a.res = sum[7:0];
			op_and_lit, op_and_file: a.res = a.w & opnd;
			op_bit_clr: a.res = a.f & ~mask;
			op_bit_set: a.res = a.f | mask;
			op_bit_skip: begin
				a.res = a.f;
				a.skip = a.f[a.bidx];
			end
			default: a.res = 8'h00;
		endcase
		a.zero = (a.res == 8'h00);
	end
endmodule : exec_alu

// >>> logic/exec_seq.sv
// Instruction cycle sequencer: four clocks per cycle, optional second cycle
`timescale 1ns/1ps
`include "exec_cfg.svh"
module exec_seq (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Core handshake
	seq_if.seq s
);
	import exec_pkg::*;
	seq_state_t state;
	logic [1:0] qtr;

	// Quarter counter
	always_ff @(posedge clk_i) begin
		if (rst_i || state == s_idle) begin
			qtr <= 2'h0;
		end else begin
			qtr <= qtr + 2'h1;
		end
	end

	// Cycle state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= s_idle;
		end else begin
			unique case (state)
				s_idle: if (s.start) state <= s_first;
				s_first: if (qtr == `QTR_LAST) state <= s.two_cycle ? s_second : s_idle;
				s_second: if (qtr == `QTR_LAST) state <= s_idle;
				default: state <= s_idle;
			endcase
		end
	end

	assign s.busy = (state != s_idle);
	assign s.second = (state == s_second);
	assign s.commit = (state == s_first) && (qtr == `QTR_LAST);
	assign s.done = (s.commit && !s.two_cycle) || (s.second && qtr == `QTR_LAST);

	a_second_len: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(s.second) |-> s.second [*4] ##1 !s.second)
		else $error("second cycle not four clocks");
endmodule : exec_seq

// >>> verif/testbench.sv
// Self-checking bench of the execution core
`timescale 1ns/1ps
`include "exec_cfg.svh"
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic busy_o;
	logic done_o;
	int fail_count = 0;
	int comparisons = 0;
	logic [31:0] expq[$];
	logic [31:0] seed = 32'h0000_001D;
	logic [7:0] w, f, k, r, s;
	logic [6:0] idx;
	logic c, dc, z;
	logic [12:0] pc = 13'h0000;

	exec_core u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.busy_o(busy_o),
		.done_o(done_o)
	);

	always #50 clk_i = ~clk_i;

	function logic [7:0] r8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : r8

	function automatic logic [11:0] fa(input logic [6:0] i);
		return {`FILE_WIN_HI, i, 2'b00};
	endfunction : fa

	task automatic complete_run();
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Read data checked against the oldest note
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			if (expq.size() == 0) begin
				chk(wb_dat_o, 32'hxxxx_xxxx);
			end else begin
				chk(wb_dat_o, expq.pop_front());
			end
		end
	end

	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, {r8(), r8(), r8(), r8()});
	endtask : rd

	task automatic run(input logic [13:0] ins, input logic skip);
		int n;
		wr(`OFF_INSTR, {18'h0_0000, ins});
		chk({31'h0, busy_o}, 32'h0000_0001);
		n = 1;
		while (done_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk(n, skip ? 32'h0000_0008 : 32'h0000_0004);
		chk({31'h0, busy_o}, 32'h0000_0000);
		pc = pc + (skip ? 13'h0002 : 13'h0001);
		rd(`OFF_PC, {19'h0_0000, pc});
	endtask : run

	task automatic load(input logic [7:0] v);
		s = r8();
		w = v;
		{z, dc, c} = s[2:0];
		wr(`OFF_WREG, {24'h00_0000, w});
		wr(`OFF_STATUS, {29'h0, z, dc, c});
	endtask : load

	task automatic state();
		rd(`OFF_WREG, {24'h00_0000, w});
		rd(`OFF_STATUS, {29'h0, z, dc, c});
	endtask : state

	task automatic add(input logic [7:0] a);
		dc = ({1'b0, w[3:0]} + {1'b0, a[3:0]}) > 5'h0F;
		{c, r} = {1'b0, w} + {1'b0, a};
		z = (r == 8'h00);
	endtask : add

	initial begin
		#3_000_000;
		fail_count++;
		complete_run();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		w = 8'h00;
		{z, dc, c} = 3'h0;
		state();
		rd(12'h100, 32'h0000_0000);
		rd(fa(7'h7F), 32'h0000_0000);
		// Literal add and AND, first pass wraps to zero
		for (int i = 0; i < 8; i++) begin
			load(i == 0 ? 8'hFF : r8());
			k = (i == 0) ? 8'h01 : r8();
			add(k);
			w = r;
			run({`OPC_ADD_LIT, i[0], k}, 1'b0);
			state();
			k = r8();
			w = w & k;
			z = (w == 8'h00);
			run({`OPC_AND_LIT, k}, 1'b0);
			state();
		end
		// Byte file add and AND with both destinations
		for (int i = 0; i < 8; i++) begin
			s = r8();
			idx = {1'b1, s[5:0]};
			f = (i == 3) ? 8'h00 : r8();
			wr(fa(idx), {24'h00_0000, f});
			load(r8());
			if (i[1]) begin
				r = w & f;
				z = (r == 8'h00);
			end else begin
				add(f);
			end
			run({i[1] ? `OPC_AND_FILE : `OPC_ADD_FILE, i[0], idx}, 1'b0);
			if (i[0]) f = r;
			else w = r;
			state();
			rd(fa(idx), {24'h00_0000, f});
		end
		// Bit clear, set and test on every bit position
		for (int b = 0; b < 8; b++) begin
			s = r8();
			idx = {1'b1, s[5:0]};
			f = r8();
			wr(fa(idx), {24'h00_0000, f});
			load(r8());
			f[b] = 1'b0;
			run({`OPC_BIT_CLR, b[2:0], idx}, 1'b0);
			rd(fa(idx), {24'h00_0000, f});
			run({`OPC_BIT_SKIP, b[2:0], idx}, 1'b0);
			rd(`OFF_CTRL, 32'h0000_0000);
			f[b] = 1'b1;
			run({`OPC_BIT_SET, b[2:0], idx}, 1'b0);
			rd(fa(idx), {24'h00_0000, f});
			run({`OPC_BIT_SKIP, b[2:0], idx}, 1'b1);
			rd(`OFF_CTRL, 32'h0000_0200);
			state();
		end
		// Clear of the top file register
		wr(fa(7'h7F), 32'h0000_00A5);
		z = 1'b1;
		run({`OPC_CLR_FILE, 7'h7F}, 1'b0);
		rd(fa(7'h7F), 32'h0000_0000);
		state();
		// Reset between instructions clears registers, flags and counters
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		pc = 13'h0000;
		w = 8'h00;
		{z, dc, c} = 3'h0;
		chk({31'h0, busy_o}, 32'h0000_0000);
		state();
		rd(fa(idx), 32'h0000_0000);
		rd(`OFF_PC, 32'h0000_0000);
		rd(`OFF_PRESC, 32'h0000_0000);
		// Timer writes with prescaler assigned
		wr(`OFF_CTRL, 32'h0000_0001);
		run({`OPC_CLR_FILE, `TIMER_ADDR}, 1'b0);
		rd(`OFF_PRESC, 32'h0000_0000);
		run({`OPC_ADD_FILE, 1'b0, `TIMER_ADDR}, 1'b0);
		rd(`OFF_PRESC, 32'h0000_0001);
		run({`OPC_AND_FILE, 1'b0, `TIMER_ADDR}, 1'b0);
		rd(`OFF_PRESC, 32'h0000_0002);
		run({`OPC_BIT_SET, 3'h2, `TIMER_ADDR}, 1'b0);
		rd(`OFF_PRESC, 32'h0000_0000);
		run({`OPC_ADD_FILE, 1'b0, `TIMER_ADDR}, 1'b0);
		run({`OPC_ADD_FILE, 1'b1, `TIMER_ADDR}, 1'b0);
		rd(`OFF_PRESC, 32'h0000_0000);
		// Unsupported code runs as one cycle
		run(14'h0000, 1'b0);
		rd(`OFF_CTRL, 32'h0000_0401);
		repeat (2) @(posedge clk_i);
		complete_run();
	end
endmodule : testbench
